// >>> logic/airc_pkg.sv
/*
  Constants for the line-input routing register pair: addresses, field
  positions, reset values and soft-step rate codes.
  Assumes a byte-wide register port with a 7-bit address in the ref_clk domain.
*/
package airc_pkg;
  localparam int          ADDR_W          = 7;
  localparam int          DATA_W          = 8;
  localparam int          LEVEL_W         = 4;
  localparam int          RATE_W          = 2;
  localparam logic [6:0]  ADDR_LEFT_ROUTE  = 7'h15;
  localparam logic [6:0]  ADDR_RIGHT_ROUTE = 7'h16;
  localparam int          DIFF_BIT        = 7;
  localparam int          LEVEL_MSB       = 6;
  localparam int          LEVEL_LSB       = 3;
  localparam int          POWER_BIT       = 2;
  localparam int          RATE_MSB        = 1;
  localparam int          RATE_LSB        = 0;
  localparam logic [2:0]  LEFT_RSVD_VALUE = 3'h0;
  localparam logic [7:0]  LEFT_RESET      = 8'h78;
  localparam logic [7:0]  RIGHT_RESET     = 8'h78;
  localparam logic [3:0]  LEVEL_MAX_GAIN  = 4'h8;
  localparam logic [3:0]  LEVEL_OFF       = 4'hF;
  localparam logic [1:0]  RATE_EVERY_FS   = 2'h0;
  localparam logic [1:0]  RATE_EVERY_2FS  = 2'h1;
  localparam logic [7:0]  RD_UNMAPPED     = 8'h00;
endpackage

// >>> logic/airc_step_if.sv
/*
  Carrier between the routing registers and the right PGA gain stepper.
  Assumes both ends sit on ref_clk.
*/
interface airc_step_if #(parameter int GAIN_W = 6);
  logic [GAIN_W-1:0] target;
  logic              fsTick;
  logic [1:0]        rate;
  logic [GAIN_W-1:0] gain;
  modport ctrl    (output target, output fsTick, output rate, input gain);
  modport stepper (input target, input fsTick, input rate, output gain);
endinterface

// >>> logic/airc_pga_stepper.sv
/*
  Right PGA gain soft-stepper: moves the applied gain one step per selected
  sample interval toward the target, or applies it at once when disabled.
  Assumes fsTick is a one-cycle pulse per sample period on ref_clk.
*/
module airc_pga_stepper
  import airc_pkg::*;
#(
  parameter int GAIN_W = 6
) (
  input  wire logic  ref_clk,
  input  wire logic  rst,
  airc_step_if.stepper stp
);
  typedef struct packed {
    logic [GAIN_W-1:0] gain;
    logic              oddTick;
  } airc_step_state_type;

  airc_step_state_type state_q;
  airc_step_state_type state_d;
  logic                stepNow;

  always_comb begin
    state_d = state_q;
    stepNow = 1'b0;
    if (stp.fsTick) begin
      state_d.oddTick = ~state_q.oddTick;
    end
    if (stp.rate == RATE_EVERY_FS) begin
      stepNow = stp.fsTick;
    end else if (stp.rate == RATE_EVERY_2FS) begin
      stepNow = stp.fsTick & state_q.oddTick;
    end
    if (stp.rate[1]) begin
      state_d.gain = stp.target;
    end else if (stepNow && stp.target > state_q.gain) begin
      state_d.gain = state_q.gain + GAIN_W'(1);
    end else if (stepNow && stp.target < state_q.gain) begin
      state_d.gain = state_q.gain - GAIN_W'(1);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign stp.gain = state_q.gain;

  property p_step_direct;
    @(posedge ref_clk) disable iff (rst)
      stp.rate[1] |=> stp.gain == $past(stp.target);
  endproperty
  a_step_direct: assert property (p_step_direct)
    else $error("disabled stepping did not apply gain at once");

  property p_step_size;
    @(posedge ref_clk) disable iff (rst)
      !stp.rate[1] |=> (stp.gain == $past(stp.gain))
        || (stp.gain == $past(stp.gain) + GAIN_W'(1))
        || (stp.gain == $past(stp.gain) - GAIN_W'(1));
  endproperty
  a_step_size: assert property (p_step_size)
    else $error("gain moved more than one step");

  property p_step_idle;
    @(posedge ref_clk) disable iff (rst)
      (!stp.rate[1] && !stp.fsTick) |=> stp.gain == $past(stp.gain);
  endproperty
  a_step_idle: assert property (p_step_idle)
    else $error("gain moved without a sample tick");

  property p_step_half;
    @(posedge ref_clk) disable iff (rst)
      (stp.rate == RATE_EVERY_2FS && stp.fsTick && !state_q.oddTick)
        |=> stp.gain == $past(stp.gain);
  endproperty
  a_step_half: assert property (p_step_half)
    else $error("half-rate stepping moved on an even tick");
endmodule // airc_pga_stepper

// >>> logic/airc_regs.sv
/*
  Routing registers for right line input one into the left and right ADC
  PGA mixers, with right ADC power and right PGA soft-step control.
  Assumes a byte register port on ref_clk and a sample tick from the ADC clocking.
*/
module airc_regs
  import airc_pkg::*;
#(
  parameter int GAIN_W = 6
) (
  input  wire logic              ref_clk,
  input  wire logic              rst,
  input  wire logic [ADDR_W-1:0] regAddr,
  input  wire logic [DATA_W-1:0] regWrData,
  input  wire logic              regWrEn,
  input  wire logic              regRdEn,
  output logic      [DATA_W-1:0] regRdData,
  input  wire logic [GAIN_W-1:0] pgaGainTarget,
  input  wire logic              fsTick,
  output logic                   leftDiffMode,
  output logic                   leftMixConnect,
  output logic      [3:0]        leftMixLevel,
  output logic                   rightDiffMode,
  output logic                   rightMixConnect,
  output logic      [3:0]        rightMixLevel,
  output logic                   rightAdcPowerUp,
  output logic      [GAIN_W-1:0] rightPgaGain
);
  typedef struct packed {
    logic [DATA_W-1:0] leftReg;
    logic [DATA_W-1:0] rightReg;
    logic              leftConnect;
    logic              rightConnect;
    logic [DATA_W-1:0] rdData;
  } airc_regs_state_type;

  airc_regs_state_type state_q;
  airc_regs_state_type state_d;
  logic [LEVEL_W-1:0]  wrLevel;
  logic                hitLeft;
  logic                hitRight;

  airc_step_if #(.GAIN_W(GAIN_W)) stepBus ();

  assign wrLevel  = regWrData[LEVEL_MSB:LEVEL_LSB];
  assign hitLeft  = (regAddr == ADDR_LEFT_ROUTE);
  assign hitRight = (regAddr == ADDR_RIGHT_ROUTE);

  always_comb begin
    state_d = state_q;
    if (regWrEn && hitLeft) begin
      state_d.leftReg = {regWrData[DIFF_BIT:LEVEL_LSB], LEFT_RSVD_VALUE};
      // Reserved codes count as disconnected
      state_d.leftConnect = (wrLevel <= LEVEL_MAX_GAIN);
    end
    if (regWrEn && hitRight) begin
      state_d.rightReg = regWrData;
      state_d.rightConnect = (wrLevel <= LEVEL_MAX_GAIN);
    end
    if (regRdEn) begin
      if (hitLeft) begin
        state_d.rdData = state_q.leftReg;
      end else if (hitRight) begin
        state_d.rdData = state_q.rightReg;
      end else begin
        state_d.rdData = RD_UNMAPPED;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_q.leftReg      <= LEFT_RESET;
      state_q.rightReg     <= RIGHT_RESET;
      state_q.leftConnect  <= 1'b0;
      state_q.rightConnect <= 1'b0;
      state_q.rdData       <= RD_UNMAPPED;
    end else begin
      state_q <= state_d;
    end
  end

  assign stepBus.target = pgaGainTarget;
  assign stepBus.fsTick = fsTick;
  assign stepBus.rate   = state_q.rightReg[RATE_MSB:RATE_LSB];

  airc_pga_stepper #(.GAIN_W(GAIN_W)) pgaStepper (
    .ref_clk (ref_clk),
    .rst     (rst),
    .stp     (stepBus.stepper)
  );

  assign regRdData       = state_q.rdData;
  assign leftDiffMode    = state_q.leftReg[DIFF_BIT];
  assign leftMixConnect  = state_q.leftConnect;
  assign leftMixLevel    = state_q.leftReg[LEVEL_MSB:LEVEL_LSB];
  assign rightDiffMode   = state_q.rightReg[DIFF_BIT];
  assign rightMixConnect = state_q.rightConnect;
  assign rightMixLevel   = state_q.rightReg[LEVEL_MSB:LEVEL_LSB];
  assign rightAdcPowerUp = state_q.rightReg[POWER_BIT];
  assign rightPgaGain    = stepBus.gain;

  property p_left_reset_off;
    @(posedge ref_clk)
      $fell(rst) |-> (!leftMixConnect && leftMixLevel == LEVEL_OFF && !leftDiffMode);
  endproperty
  a_left_reset_off: assert property (p_left_reset_off)
    else $error("left route not disconnected after reset");

  property p_right_reset_off;
    @(posedge ref_clk)
      $fell(rst) |-> (!rightMixConnect && rightMixLevel == LEVEL_OFF && !rightAdcPowerUp);
  endproperty
  a_right_reset_off: assert property (p_right_reset_off)
    else $error("right route not disconnected after reset");

  property p_left_diff;
    @(posedge ref_clk) disable iff (rst)
      (regWrEn && hitLeft) |=> leftDiffMode == $past(regWrData[DIFF_BIT]);
  endproperty
  a_left_diff: assert property (p_left_diff)
    else $error("left wiring bit not taken from write");

  property p_left_connect;
    @(posedge ref_clk) disable iff (rst)
      (regWrEn && hitLeft && wrLevel <= LEVEL_MAX_GAIN)
        |=> (leftMixConnect && leftMixLevel == $past(wrLevel));
  endproperty
  a_left_connect: assert property (p_left_connect)
    else $error("valid left level did not connect");

  property p_left_off;
    @(posedge ref_clk) disable iff (rst)
      (regWrEn && hitLeft && wrLevel == LEVEL_OFF) |=> !leftMixConnect;
  endproperty
  a_left_off: assert property (p_left_off)
    else $error("left off code left input connected");

  property p_right_connect;
    @(posedge ref_clk) disable iff (rst)
      (regWrEn && hitRight) |=> (rightMixConnect == ($past(wrLevel) <= LEVEL_MAX_GAIN))
        && rightMixLevel == $past(wrLevel);
  endproperty
  a_right_connect: assert property (p_right_connect)
    else $error("right connect does not follow level code");

  property p_left_rsvd;
    @(posedge ref_clk) disable iff (rst)
      (regRdEn && hitLeft) |=> regRdData[2:0] == LEFT_RSVD_VALUE;
  endproperty
  a_left_rsvd: assert property (p_left_rsvd)
    else $error("left reserved bits read nonzero");

  property p_right_power;
    @(posedge ref_clk) disable iff (rst)
      (regWrEn && hitRight) |=> rightAdcPowerUp == $past(regWrData[POWER_BIT]);
  endproperty
  a_right_power: assert property (p_right_power)
    else $error("right power bit not taken from write");

  property p_right_diff;
    @(posedge ref_clk) disable iff (rst)
      (regWrEn && hitRight) |=> rightDiffMode == $past(regWrData[DIFF_BIT]);
  endproperty
  a_right_diff: assert property (p_right_diff)
    else $error("right wiring bit not taken from write");

  property p_left_level;
    @(posedge ref_clk) disable iff (rst)
      (regWrEn && hitLeft) |=> leftMixLevel == $past(wrLevel);
  endproperty
  a_left_level: assert property (p_left_level)
    else $error("left level not taken from write");

  property p_left_far_code;
    @(posedge ref_clk) disable iff (rst)
      (regWrEn && hitLeft && wrLevel > LEVEL_MAX_GAIN) |=> !leftMixConnect;
  endproperty
  a_left_far_code: assert property (p_left_far_code)
    else $error("left input connected without a gain code");

  property p_right_off;
    @(posedge ref_clk) disable iff (rst)
      (regWrEn && hitRight && wrLevel == LEVEL_OFF) |=> !rightMixConnect;
  endproperty
  a_right_off: assert property (p_right_off)
    else $error("right off code left input connected");

  property p_right_rate;
    @(posedge ref_clk) disable iff (rst)
      (regWrEn && hitRight) |=> stepBus.rate == $past(regWrData[RATE_MSB:RATE_LSB]);
  endproperty
  a_right_rate: assert property (p_right_rate)
    else $error("step rate not taken from write");

  property p_left_hold;
    @(posedge ref_clk) disable iff (rst)
      !(regWrEn && hitLeft)
        |=> $stable(leftMixLevel) && $stable(leftMixConnect) && $stable(leftDiffMode);
  endproperty
  a_left_hold: assert property (p_left_hold)
    else $error("left route changed without a write");

  property p_right_hold;
    @(posedge ref_clk) disable iff (rst)
      !(regWrEn && hitRight)
        |=> $stable(rightMixLevel) && $stable(rightAdcPowerUp) && $stable(rightDiffMode);
  endproperty
  a_right_hold: assert property (p_right_hold)
    else $error("right route changed without a write");
endmodule // airc_regs

// >>> tb/airc_regs_tb.sv
/*
  Self-checking bench for the routing register pair and the right PGA stepper.
  Assumes airc_pkg is compiled first and the design sits on one 40 MHz clock.
*/
module airc_regs_tb
  import airc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int LIMIT = 3000;

  logic              ref_clk = 1'b0;
  logic              rst = 1'b1;
  logic [ADDR_W-1:0] regAddr = 7'h00;
  logic [DATA_W-1:0] regWrData = 8'h00;
  logic              regWrEn = 1'b0;
  logic              regRdEn = 1'b0;
  logic [DATA_W-1:0] regRdData;
  logic [5:0]        pgaGainTarget = 6'h00;
  logic              fsTick = 1'b0;
  logic              leftDiffMode, leftMixConnect, rightDiffMode, rightMixConnect;
  logic              rightAdcPowerUp;
  logic [3:0]        leftMixLevel, rightMixLevel;
  logic [5:0]        rightPgaGain, expGain, tgt;
  logic [7:0]        rd, d;
  logic [3:0]        lvl;
  logic [31:0]       seed = 32'h0000001B;
  int                errors = 0;
  int                nChecks = 0;
  int                cycles = 0;
  int                ticks = 0;

  airc_regs #(.GAIN_W(6)) airc_regs_inst (
    .ref_clk(ref_clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
    .pgaGainTarget(pgaGainTarget), .fsTick(fsTick), .leftDiffMode(leftDiffMode),
    .leftMixConnect(leftMixConnect), .leftMixLevel(leftMixLevel),
    .rightDiffMode(rightDiffMode), .rightMixConnect(rightMixConnect),
    .rightMixLevel(rightMixLevel), .rightAdcPowerUp(rightAdcPowerUp),
    .rightPgaGain(rightPgaGain)
  );

  always #12.5 ref_clk = ~ref_clk;

  function automatic logic [31:0] nextRand();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [5:0] stepToward(input logic [5:0] g, input logic [5:0] t);
    return (g < t) ? g + 6'h01 : ((g > t) ? g - 6'h01 : g);
  endfunction

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    nChecks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic regAccess(input logic wr, input logic [6:0] a, input logic [7:0] wd);
    @(posedge ref_clk);
    regAddr   <= a;
    regWrData <= wd;
    regWrEn   <= wr;
    regRdEn   <= ~wr;
    @(posedge ref_clk);
    regWrEn <= 1'b0;
    regRdEn <= 1'b0;
    #1;
    rd = regRdData;
  endtask

  task automatic tallyAndFinish();
    $display("checks %0d errors %0d", nChecks, errors);
    if (errors == 0 && nChecks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic resetChecks();
    regAccess(1'b0, ADDR_LEFT_ROUTE, 8'h00);
    check("left reset", rd, LEFT_RESET);
    regAccess(1'b0, ADDR_RIGHT_ROUTE, 8'h00);
    check("right reset", rd, RIGHT_RESET);
    check("reset outputs", {3'h0, leftDiffMode, leftMixConnect, rightMixConnect,
                            rightAdcPowerUp, rightDiffMode}, 8'h00);
    check("reset levels", {leftMixLevel, rightMixLevel}, {LEVEL_OFF, LEVEL_OFF});
    check("reset gain", {2'h0, rightPgaGain}, 8'h00);
  endtask

  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      errors++;
      tallyAndFinish();
    end
  end

  initial begin
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    resetChecks();
    // Valid level codes only, same wiring bit in both registers
    for (int i = 0; i < 10; i++) begin
      lvl = (i == 9) ? LEVEL_OFF : i[3:0];
      d = 8'(nextRand());
      d[6:3] = lvl;
      regAccess(1'b1, ADDR_LEFT_ROUTE, d & 8'hF8);
      regAccess(1'b1, ADDR_RIGHT_ROUTE, d);
      regAccess(1'b0, ADDR_LEFT_ROUTE, 8'h00);
      check("left readback", rd, d & 8'hF8);
      regAccess(1'b0, ADDR_RIGHT_ROUTE, 8'h00);
      check("right readback", rd, d);
      check("left outputs", {2'h0, leftDiffMode, leftMixConnect, leftMixLevel},
            {2'h0, d[7], lvl <= LEVEL_MAX_GAIN, lvl});
      check("right outputs", {1'b0, rightAdcPowerUp, rightDiffMode, rightMixConnect,
            rightMixLevel}, {1'b0, d[2], d[7], lvl <= LEVEL_MAX_GAIN, lvl});
    end
    regAccess(1'b1, 7'h17, 8'hFF);
    regAccess(1'b0, 7'h17, 8'h00);
    check("unmapped read", rd, RD_UNMAPPED);
    check("left level kept", {4'h0, leftMixLevel}, {4'h0, lvl});
    check("right level kept", {4'h0, rightMixLevel}, {4'h0, lvl});
    expGain = 6'h00;
    for (int rt = 3; rt >= 0; rt--) begin
      regAccess(1'b1, ADDR_RIGHT_ROUTE, {1'b0, LEVEL_OFF, 1'b0, rt[1:0]});
      tgt = (expGain < 6'h3A) ? expGain + 6'h04 : expGain - 6'h04;
      if (rt > 1) begin
        tgt = 6'(nextRand());
      end
      @(posedge ref_clk);
      pgaGainTarget <= tgt;
      @(posedge ref_clk);
      #1;
      if (rt > 1) begin
        expGain = tgt;
        check("gain at once", {2'h0, rightPgaGain}, {2'h0, expGain});
      end else begin
        for (int k = 0; k < 6; k++) begin
          @(posedge ref_clk);
          fsTick <= 1'b1;
          @(posedge ref_clk);
          fsTick <= 1'b0;
          #1;
          ticks++;
          if (rt == 0 || ticks % 2 == 0) begin
            expGain = stepToward(expGain, tgt);
          end
          check("stepped gain", {2'h0, rightPgaGain}, {2'h0, expGain});
        end
      end
    end
    // Second reset in mid-run, after the gain has moved
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    #1;
    check("gain in reset", {2'h0, rightPgaGain}, 8'h00);
    resetChecks();
    tallyAndFinish();
  end
endmodule // airc_regs_tb
